// File: pmi_ctrl.sv
// Local design decision: the AHB-Lite interface to the registers.
module pmi_ctrl (
	// clock and reset
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	// ahb-lite slave
	input  wire pmi_pkg::pmi_ahb_req_t ahb,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	// cpu side
	output pmi_pkg::pmi_irq_t         irq,
	input  wire logic                 int_ack,
	input  wire logic                 int_return,
	input  wire logic                 cpu_instr_done,
	// event sources
	input  wire logic [14:0]          periph_evt,
	input  wire logic [2:0]           ext_pin_n,
	input  wire logic [15:0]          port_pin,
	input  wire logic [3:0]           unit_on_slow,
	// clock gating
	output logic                      cpu_clk_en,
	output logic                      periph_clk_en,
	output logic                      fast_clk_en,
	output logic                      slow_clk_en,
	output logic [3:0]                keep_clk_en
);
	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [2:0]        pin_s1;
		logic [2:0]        pin_s2;
		logic [2:0]        pin_s3;
		logic [15:0]       port_s1;
		logic [15:0]       port_s2;
		logic [15:0]       port_s3;
		logic [7:0]        power_control;
		logic [1:0]        option;
		logic [7:0]        p1_wake;
		logic [7:0]        p23_wake;
		logic [7:0]        ie_main;
		logic [7:0]        ie_extra;
		logic [7:0]        prio_lo_a;
		logic [7:0]        prio_hi_a;
		logic [7:0]        prio_lo_b;
		logic [7:0]        prio_hi_b;
		logic [14:0]       flags;
		logic [3:0]        active;
		pmi_pkg::pmi_mode_t mode;
		logic              hold;
		logic              req;
		logic [3:0]        slot;
		logic [1:0]        lvl;
		logic              wr_pend;
		logic [7:0]        wr_idx;
		logic [31:0]       rdata;
	} pmi_state_t;

	pmi_state_t q;
	pmi_state_t d;

	// enable and priority vectors in slot order
	logic [14:0] en_vec;
	logic [14:0] pri_hi;
	logic [14:0] pri_lo;
	logic [2:0]  fall;
	logic        pchg;
	logic [14:0] ev;
	logic [14:0] pend;
	logic        pin_block;
	logic        pin_wake;
	logic        halt_wake;
	logic [2:0]  cur;
	logic        found;
	logic [3:0]  best;
	logic [1:0]  best_lvl;

	////////////////////////////////////////////////////////////////////////////
	// highest level in service, bit 2 marks any
	function automatic logic [2:0] top_level(input logic [3:0] act);
		top_level = 3'h0;
		for (int i = 0; i < 4; i++) begin
			if (act[i]) begin
				top_level = {1'b1, 2'(i)};
			end
		end
	endfunction

	// register read mux
	function automatic logic [31:0] read_reg(input pmi_state_t s, input logic [7:0] idx);
		read_reg = 32'h0000_0000;
		unique case (idx)
			pmi_pkg::IDX_POWER_CONTROL: read_reg[7:0] = s.power_control;
			pmi_pkg::IDX_PORT1_WAKE:    read_reg[7:0] = s.p1_wake;
			pmi_pkg::IDX_PORT23_WAKE:   read_reg[7:0] = s.p23_wake;
			pmi_pkg::IDX_ENABLE_MAIN:   read_reg[7:0] = s.ie_main;
			pmi_pkg::IDX_ENABLE_EXTRA:  read_reg[7:0] = s.ie_extra;
			pmi_pkg::IDX_PRIO_LOW_A:    read_reg[7:0] = s.prio_lo_a;
			pmi_pkg::IDX_PRIO_HIGH_A:   read_reg[7:0] = s.prio_hi_a;
			pmi_pkg::IDX_PRIO_LOW_B:    read_reg[7:0] = s.prio_lo_b;
			pmi_pkg::IDX_PRIO_HIGH_B:   read_reg[7:0] = s.prio_hi_b;
			pmi_pkg::IDX_FLAGS:         read_reg[14:0] = s.flags;
			pmi_pkg::IDX_STATUS:        read_reg[12:0] = {s.slot, s.req, s.active, s.hold, 1'b0, s.mode};
			pmi_pkg::IDX_POWER_OPTION:  read_reg[1:0] = s.option;
			default:                    read_reg = 32'h0000_0000;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// per-source enable and priority: main/low-a cover slots 0..5, extra/b cover 7..14
	assign en_vec = {q.ie_extra, 1'b0, q.ie_main[5:0]};
	assign pri_hi = {q.prio_hi_b, 1'b0, q.prio_hi_a[5:0]};
	assign pri_lo = {q.prio_lo_b, 1'b0, q.prio_lo_a[5:0]};

	// falling edges on synchronised pins, pin change on enabled port pins
	assign fall = q.pin_s3 & ~q.pin_s2;
	assign pchg = |((q.port_s2 ^ q.port_s3) & {q.p23_wake, q.p1_wake});

	// event vector per slot; pin slots come from the pin logic only
	always_comb begin
		ev = periph_evt;
		ev[pmi_pkg::SLOT_RSVD] = 1'b0;
		ev[pmi_pkg::SLOT_INT0] = fall[0];
		ev[pmi_pkg::SLOT_INT1] = fall[1];
		ev[pmi_pkg::SLOT_INT2] = fall[2];
		ev[pmi_pkg::SLOT_PNC]  = pchg;
	end

	// serviceable sources need own and global enable
	assign pend = q.flags & en_vec & {15{q.ie_main[pmi_pkg::BIT_GLOBAL]}};

	// enabled external pin held low blocks power-down
	assign pin_block = |(~q.pin_s2 & {q.ie_extra[2], q.ie_main[2], q.ie_main[0]});

	// pin wake-up ignores the global enable
	assign pin_wake = |(fall & {q.ie_extra[2], q.ie_main[2], q.ie_main[0]}) | pchg;
	assign halt_wake = pin_wake
		| (q.flags[pmi_pkg::SLOT_RTC] & en_vec[pmi_pkg::SLOT_RTC])
		| (q.flags[pmi_pkg::SLOT_PWM] & en_vec[pmi_pkg::SLOT_PWM]);

	// pick highest level above the one in service, lowest slot on ties
	assign cur = top_level(q.active);
	always_comb begin
		found = 1'b0;
		best = 4'h0;
		best_lvl = 2'h0;
		for (int i = pmi_pkg::NSRC - 1; i >= 0; i--) begin
			if (pend[i] && (!cur[2] || {pri_hi[i], pri_lo[i]} > cur[1:0])) begin
				if (!found || {pri_hi[i], pri_lo[i]} >= best_lvl) begin
					found = 1'b1;
					best = 4'(i);
					best_lvl = {pri_hi[i], pri_lo[i]};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [14:0] clr;
		logic [7:0]  w8;
		clr = 15'h0000;
		w8 = ahb.hwdata[7:0];
		d = q;
		// two-flop synchronisers plus one history stage
		d.pin_s1 = ext_pin_n;
		d.pin_s2 = q.pin_s1;
		d.pin_s3 = q.pin_s2;
		d.port_s1 = port_pin;
		d.port_s2 = q.port_s1;
		d.port_s3 = q.port_s2;
		// data-phase register writes
		if (q.wr_pend) begin
			unique case (q.wr_idx)
				pmi_pkg::IDX_POWER_CONTROL: begin
					d.power_control = w8;
					if (pin_block) begin
						d.power_control[pmi_pkg::BIT_POWER_DOWN] = 1'b0;
					end
				end
				pmi_pkg::IDX_PORT1_WAKE:   d.p1_wake = w8;
				pmi_pkg::IDX_PORT23_WAKE:  d.p23_wake = w8;
				pmi_pkg::IDX_ENABLE_MAIN:  d.ie_main = {w8[7], 1'b0, w8[5:0]};
				pmi_pkg::IDX_ENABLE_EXTRA: d.ie_extra = w8;
				pmi_pkg::IDX_PRIO_LOW_A:   d.prio_lo_a = {2'h0, w8[5:0]};
				pmi_pkg::IDX_PRIO_HIGH_A:  d.prio_hi_a = {2'h0, w8[5:0]};
				pmi_pkg::IDX_PRIO_LOW_B:   d.prio_lo_b = w8;
				pmi_pkg::IDX_PRIO_HIGH_B:  d.prio_hi_b = w8;
				pmi_pkg::IDX_FLAGS:        clr = ~ahb.hwdata[14:0];
				pmi_pkg::IDX_POWER_OPTION: d.option = ahb.hwdata[1:0];
				default: ;
			endcase
		end
		// entry to service clears pin flags
		if (int_ack && q.req) begin
			d.active[q.lvl] = 1'b1;
			if (q.slot == 4'(pmi_pkg::SLOT_INT0) || q.slot == 4'(pmi_pkg::SLOT_INT1)
				|| q.slot == 4'(pmi_pkg::SLOT_INT2) || q.slot == 4'(pmi_pkg::SLOT_PNC)) begin
				clr[q.slot] = 1'b1;
			end
		end else if (int_return && cur[2]) begin
			d.active[cur[1:0]] = 1'b0;
		end
		// events set flags whatever the enables; set wins over clear
		d.flags = (q.flags & ~clr) | ev;
		// power mode sequencing
		unique case (q.mode)
			pmi_pkg::mode_run: begin
				if (q.power_control[pmi_pkg::BIT_POWER_DOWN]) begin
					d.mode = q.option[pmi_pkg::BIT_HALT_SEL] ? pmi_pkg::mode_stop
						: pmi_pkg::mode_halt;
				end else if (q.power_control[pmi_pkg::BIT_SLEEP]) begin
					d.mode = pmi_pkg::mode_idle;
				end
			end
			pmi_pkg::mode_idle: begin
				if (|pend) begin
					d.mode = pmi_pkg::mode_run;
					d.power_control[pmi_pkg::BIT_SLEEP] = 1'b0;
				end
			end
			pmi_pkg::mode_halt: begin
				if (halt_wake) begin
					d.mode = pmi_pkg::mode_run;
					d.hold = 1'b1;
					d.power_control[pmi_pkg::BIT_POWER_DOWN] = 1'b0;
				end
			end
			pmi_pkg::mode_stop: begin
				if (pin_wake) begin
					d.mode = pmi_pkg::mode_run;
					d.hold = 1'b1;
					d.power_control[pmi_pkg::BIT_POWER_DOWN] = 1'b0;
				end
			end
		endcase
		// one instruction after power-down wake before any service
		if (q.hold && q.mode == pmi_pkg::mode_run && cpu_instr_done) begin
			d.hold = 1'b0;
		end
		// registered request, vector and level
		d.req = found && q.mode == pmi_pkg::mode_run && !q.hold && !(int_ack && q.req);
		d.slot = best;
		d.lvl = best_lvl;
		// address phase capture
		d.wr_pend = 1'b0;
		if (ahb.hsel && hready && ahb.htrans[1]) begin
			d.wr_idx = (ahb.haddr[31:10] == 22'h0) ? ahb.haddr[9:2] : 8'h00;
			d.wr_pend = ahb.hwrite;
			if (!ahb.hwrite) begin
				d.rdata = (ahb.haddr[31:10] == 22'h0) ? read_reg(q, ahb.haddr[9:2])
					: 32'h0000_0000;
			end
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.pin_s1 <= 3'h7;
			q.pin_s2 <= 3'h7;
			q.pin_s3 <= 3'h7;
			q.option <= pmi_pkg::RST_OPTION;
			q.mode <= pmi_pkg::mode_run;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = q.rdata;
	assign irq.req = q.req & q.ie_main[pmi_pkg::BIT_GLOBAL] & ~q.hold;
	assign irq.vector = pmi_pkg::VEC_BASE + {9'h000, q.slot, 3'h0};
	assign irq.level = q.lvl;

	// clock enables per mode
	assign cpu_clk_en = q.mode == pmi_pkg::mode_run;
	assign periph_clk_en = cpu_clk_en
		| (q.mode == pmi_pkg::mode_idle & ~q.option[pmi_pkg::BIT_PERIPH_GATE]);
	assign fast_clk_en = ~q.mode[1];
	assign slow_clk_en = q.mode != pmi_pkg::mode_stop;
	assign keep_clk_en = {4{~q.mode[1]}}
		| ({4{q.mode == pmi_pkg::mode_halt}} & unit_on_slow);

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	refuse_power_down_a: assert property (q.wr_pend && q.wr_idx == pmi_pkg::IDX_POWER_CONTROL
		&& pin_block |=> !q.power_control[pmi_pkg::BIT_POWER_DOWN]) else $error("power-down not refused");
	idle_entry_a: assert property (q.mode == pmi_pkg::mode_run && q.power_control[1:0] == 2'b01
		|=> q.mode == pmi_pkg::mode_idle ##0 !cpu_clk_en) else $error("idle not entered");
	stop_entry_a: assert property (q.mode == pmi_pkg::mode_run && q.power_control[pmi_pkg::BIT_POWER_DOWN]
		&& q.option[pmi_pkg::BIT_HALT_SEL] |=> !slow_clk_en) else $error("stop not entered");
	stop_hold_a: assert property (q.mode == pmi_pkg::mode_stop && !pin_wake
		|=> q.mode == pmi_pkg::mode_stop) else $error("stop left without pin");
	halt_wake_a: assert property (q.mode == pmi_pkg::mode_halt && q.flags[pmi_pkg::SLOT_PWM]
		&& q.ie_extra[6] |=> q.mode == pmi_pkg::mode_run && q.hold) else $error("pwm no wake");
	idle_gate_a: assert property (q.mode == pmi_pkg::mode_idle
		|-> periph_clk_en == !q.option[pmi_pkg::BIT_PERIPH_GATE]) else $error("idle gating");
	flag_set_a: assert property (periph_evt[1] |=> q.flags[1]) else $error("flag lost");
	req_global_a: assert property (irq.req |-> q.ie_main[pmi_pkg::BIT_GLOBAL]
		&& q.flags[q.slot] && en_vec[q.slot]) else $error("request not enabled");
	wake_clear_a: assert property (q.mode != pmi_pkg::mode_run ##1 q.mode == pmi_pkg::mode_run
		|-> q.power_control[1:0] == 2'b00) else $error("request bits left set");
	hold_block_a: assert property ($rose(q.hold) |-> !q.req [*2]) else $error("early service");
	nest_level_a: assert property (irq.req && cur[2] |-> q.lvl > cur[1:0]
		or $past(q.active) != q.active) else $error("bad preempt");
	pin_clear_a: assert property (int_ack && q.req && q.slot == 4'h0 && !ev[0]
		|=> !q.flags[0]) else $error("pin flag kept");

	idle_wake_c: cover property (q.mode == pmi_pkg::mode_idle ##1 q.mode == pmi_pkg::mode_run);
	stop_wake_c: cover property (q.mode == pmi_pkg::mode_stop ##1 q.mode == pmi_pkg::mode_run);
	nested_c: cover property ($countones(q.active) == 2);
endmodule

// File: pmi_pkg.sv
package pmi_pkg;
	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
	localparam logic [7:0] IDX_PORT1_WAKE    = 8'h96;
	localparam logic [7:0] IDX_PORT23_WAKE   = 8'hA1;
	localparam logic [7:0] IDX_ENABLE_MAIN   = 8'hA8;
	localparam logic [7:0] IDX_ENABLE_EXTRA  = 8'hA9;
	localparam logic [7:0] IDX_PRIO_LOW_A    = 8'hB8;
	localparam logic [7:0] IDX_PRIO_HIGH_A   = 8'hB9;
	localparam logic [7:0] IDX_PRIO_LOW_B    = 8'hBA;
	localparam logic [7:0] IDX_PRIO_HIGH_B   = 8'hBB;
	localparam logic [7:0] IDX_FLAGS         = 8'hC0;
	localparam logic [7:0] IDX_STATUS        = 8'hC1;
	localparam logic [7:0] IDX_POWER_OPTION  = 8'hC2;
	// field positions
	localparam int BIT_SLEEP      = 0;
	localparam int BIT_POWER_DOWN = 1;
	localparam int BIT_GLOBAL     = 7;
	localparam int BIT_HALT_SEL   = 0;
	localparam int BIT_PERIPH_GATE = 1;
	// reset values
	localparam logic [7:0] RST_REG8   = 8'h00;
	localparam logic [1:0] RST_OPTION = 2'h1;
	// source slots, vector = base + 8 * slot
	localparam int NSRC      = 15;
	localparam int SLOT_INT0 = 0;
	localparam int SLOT_INT1 = 2;
	localparam int SLOT_RSVD = 6;
	localparam int SLOT_RTC  = 7;
	localparam int SLOT_PNC  = 8;
	localparam int SLOT_INT2 = 9;
	localparam int SLOT_PWM  = 13;
	localparam logic [15:0] VEC_BASE = 16'h0003;
	// operating modes
	typedef enum logic [1:0] {
		mode_run  = 2'b00,
		mode_idle = 2'b01,
		mode_halt = 2'b10,
		mode_stop = 2'b11
	} pmi_mode_t;
	// bus request as seen in the address phase
	typedef struct packed {
		logic        hsel;
		logic [1:0]  htrans;
		logic [31:0] haddr;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
	} pmi_ahb_req_t;
	// interrupt request towards the cpu
	typedef struct packed {
		logic        req;
		logic [15:0] vector;
		logic [1:0]  level;
	} pmi_irq_t;
endpackage

// File: pmi_cpu_model.sv
////////////////////////////////////////////////////////////////////////////////
// cpu core stand-in: takes standing requests, returns on demand, retires instructions
module pmi_cpu_model (
	// clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// controller side
	input  wire pmi_pkg::pmi_irq_t irq,
	input  wire logic              cpu_clk_en,
	output logic                   int_ack,
	output logic                   int_return,
	output logic                   cpu_instr_done,
	// bench control and observation
	input  wire logic [1:0]        ack_wait,
	input  wire logic              ret_req,
	output int                     n_ack,
	output logic [15:0]            last_vec,
	output logic [1:0]             last_lvl
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt_q;

	////////////////////////////////////////////////////////////////////////////////
	// a request is taken after ack_wait cycles, only while the core is clocked
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_ack        <= 1'b0;
			int_return     <= 1'b0;
			cpu_instr_done <= 1'b0;
			cnt_q          <= 2'h0;
			n_ack          <= 0;
			last_vec       <= 16'h0000;
			last_lvl       <= 2'h0;
		end else begin
			int_return     <= ret_req;
			cpu_instr_done <= cpu_clk_en; // one instruction per clocked cycle
			if (int_ack) begin
				int_ack <= 1'b0; // one-cycle pulse, never a second ack on the same request
				cnt_q   <= 2'h0;
			end else if (irq.req && cpu_clk_en) begin
				if (cnt_q == ack_wait) begin
					int_ack  <= 1'b1;
					n_ack    <= n_ack + 1;
					last_vec <= irq.vector;
					last_lvl <= irq.level;
				end else begin
					cnt_q <= cnt_q + 2'h1;
				end
			end else begin
				cnt_q <= 2'h0;
			end
		end
	end
endmodule

// File: power_mode_interrupt_wakeup_tb.sv
module power_mode_interrupt_wakeup_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  hclk = 1'b0;
	logic                  hresetn = 1'b0;
	pmi_pkg::pmi_ahb_req_t ahb = '0;
	pmi_pkg::pmi_irq_t     irq;
	logic                  hreadyout, hresp, int_ack, int_return, cpu_instr_done;
	logic                  cpu_clk_en, periph_clk_en, fast_clk_en, slow_clk_en;
	logic [31:0]           rd;
	logic [31:0]           rd_bus;
	logic [14:0]           periph_evt = '0;
	logic [2:0]            ext_pin_n = 3'h7;
	logic [15:0]           port_pin = '0;
	logic [15:0]           last_vec;
	logic [3:0]            unit_on_slow = '0;
	logic [3:0]            keep_clk_en;
	logic [1:0]            ack_wait = '0;
	logic [1:0]            last_lvl;
	logic                  ret_req = 1'b0;
	logic [7:0]            pr [4];
	int                    n_ack, na, s, d;
	int                    n_mismatch = 0;
	int                    checks_done = 0;
	int                    pslot [10] = '{1, 3, 4, 5, 7, 10, 11, 12, 13, 14};

	pmi_ctrl pmi_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .ahb(ahb), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(rd_bus), .irq(irq), .int_ack(int_ack),
		.int_return(int_return), .cpu_instr_done(cpu_instr_done), .periph_evt(periph_evt),
		.ext_pin_n(ext_pin_n), .port_pin(port_pin), .unit_on_slow(unit_on_slow),
		.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .fast_clk_en(fast_clk_en),
		.slow_clk_en(slow_clk_en), .keep_clk_en(keep_clk_en));
	pmi_cpu_model pmi_cpu_model_inst (.hclk(hclk), .hresetn(hresetn), .irq(irq),
		.cpu_clk_en(cpu_clk_en), .int_ack(int_ack), .int_return(int_return),
		.cpu_instr_done(cpu_instr_done), .ack_wait(ack_wait), .ret_req(ret_req),
		.n_ack(n_ack), .last_vec(last_vec), .last_lvl(last_lvl));

	////////////////////////////////////////////////////////////////////////////////
	// clock, expectations and bus cycles
	always #2 hclk = ~hclk;
	function automatic logic [15:0] vec_of(input int k);
		return 16'h0003 + 16'(8 * k);
	endfunction
	function automatic logic [1:0] lvl_of(input int k);
		if (k < 6)
			return {pr[1][k], pr[0][k]};
		return {pr[3][k - 7], pr[2][k - 7]};
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// address phase held until hready, then data phase held until hready
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge hclk);
		ahb.hsel   <= 1'b1;
		ahb.htrans <= 2'h2;
		ahb.haddr  <= {22'h0, idx, 2'h0};
		ahb.hwrite <= wr;
		ahb.hsize  <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		ahb.htrans <= 2'h0;
		ahb.hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = rd_bus;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		bus(1'b1, idx, wd);
	endtask
	task automatic rchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		check(what, rd, exp);
	endtask
	task automatic fire(input int k);
		na = n_ack;
		@(posedge hclk);
		periph_evt <= 15'h0001 << k;
		@(posedge hclk);
		periph_evt <= '0;
	endtask
	task automatic ret();
		@(posedge hclk);
		ret_req <= 1'b1;
		@(posedge hclk);
		ret_req <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask
	// waits for one acknowledge, then compares vector and level
	task automatic take(input int k);
		repeat (40) if (n_ack == na) @(posedge hclk);
		check("ack count", 32'(n_ack - na), 32'h1);
		check("vector", 32'(last_vec), 32'(vec_of(k)));
		check("level", 32'(last_lvl), 32'(lvl_of(k)));
	endtask
	task automatic wake();
		repeat (20) if (cpu_clk_en !== 1'b1) @(posedge hclk);
		check("woken", 32'(cpu_clk_en), 32'h1);
		rchk("request bits cleared", pmi_pkg::IDX_POWER_CONTROL, 32'h0);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// watchdog, far above the length of the sequence
	initial begin
		#80000;
		n_mismatch++;
		give_verdict();
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		s = $urandom(32'hC8CF3A32);
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		// reset values, option register, unmapped place, wake enables
		rchk("control reset", pmi_pkg::IDX_POWER_CONTROL, 32'h0);
		rchk("enable reset", pmi_pkg::IDX_ENABLE_EXTRA, 32'h0);
		rchk("option reset", pmi_pkg::IDX_POWER_OPTION, 32'h1);
		wr(8'h10, 32'hFF);
		rchk("unmapped", 8'h10, 32'h0);
		d = $urandom_range(255);
		wr(pmi_pkg::IDX_PORT1_WAKE, 32'(d));
		rchk("port1 wake", pmi_pkg::IDX_PORT1_WAKE, 32'(d));
		wr(pmi_pkg::IDX_PORT23_WAKE, 32'(~d & 255));
		rchk("port23 wake", pmi_pkg::IDX_PORT23_WAKE, 32'(~d & 255));
		wr(pmi_pkg::IDX_PORT1_WAKE, 32'h0);
		wr(pmi_pkg::IDX_PORT23_WAKE, 32'h0);
		// flag set with enable clear; own enable alone does not serve
		fire(1);
		rchk("flag without enable", pmi_pkg::IDX_FLAGS, 32'h2);
		wr(pmi_pkg::IDX_ENABLE_MAIN, 32'h02);
		repeat (5) @(posedge hclk);
		check("served without global", 32'(n_ack - na), 32'h0);
		wr(pmi_pkg::IDX_FLAGS, 32'h0);
		// all peripheral slots, random priorities and answer delays
		for (int i = 0; i < 4; i++) begin
			pr[i] = 8'($urandom);
			wr(pmi_pkg::IDX_PRIO_LOW_A + 8'(i), 32'(pr[i]));
		end
		wr(pmi_pkg::IDX_ENABLE_MAIN, 32'hBE);
		wr(pmi_pkg::IDX_ENABLE_EXTRA, 32'hF9);
		foreach (pslot[i]) begin
			ack_wait <= 2'($urandom);
			fire(pslot[i]);
			take(pslot[i]);
			wr(pmi_pkg::IDX_FLAGS, 32'h7FFF & ~(32'h1 << pslot[i]));
			ret();
		end
		// nesting: level 1 then level 3 preempts, level 0 waits for both returns
		pr[0] = 8'h0A;
		pr[1] = 8'h08;
		wr(pmi_pkg::IDX_PRIO_LOW_A, 32'h0A);
		wr(pmi_pkg::IDX_PRIO_HIGH_A, 32'h08);
		fire(1);
		take(1);
		fire(3);
		take(3);
		wr(pmi_pkg::IDX_FLAGS, 32'h7FF5);
		fire(4);
		repeat (20) @(posedge hclk);
		check("lower waits", 32'(n_ack - na), 32'h0);
		ret();
		repeat (20) @(posedge hclk);
		check("lower still waits", 32'(n_ack - na), 32'h0);
		ret();
		take(4);
		wr(pmi_pkg::IDX_FLAGS, 32'h0);
		ret();
		// idle with and without the peripheral clock gate
		for (int g = 1; g >= 0; g--) begin
			wr(pmi_pkg::IDX_POWER_OPTION, 32'(g << 1));
			wr(pmi_pkg::IDX_POWER_CONTROL, 32'h01);
			repeat (3) @(posedge hclk);
			check("idle clocks", 32'({cpu_clk_en, fast_clk_en}), 32'h1);
			check("idle periph clock", 32'(periph_clk_en), 32'(1 - g));
			fire(1);
			take(1);
			wake();
			wr(pmi_pkg::IDX_FLAGS, 32'h0);
			ret();
		end
		// halt woken by pwm then timer3 with global enable clear
		wr(pmi_pkg::IDX_ENABLE_MAIN, 32'h0);
		wr(pmi_pkg::IDX_POWER_OPTION, 32'h0);
		for (int j = 0; j < 2; j++) begin
			unit_on_slow <= 4'($urandom);
			wr(pmi_pkg::IDX_ENABLE_EXTRA, j ? 32'h01 : 32'h40);
			wr(pmi_pkg::IDX_POWER_CONTROL, 32'h02);
			repeat (3) @(posedge hclk);
			check("halt clocks", 32'({cpu_clk_en, fast_clk_en, slow_clk_en}), 32'h1);
			check("halt kept units", 32'(keep_clk_en), 32'(unit_on_slow));
			fire(j ? pmi_pkg::SLOT_RTC : pmi_pkg::SLOT_PWM);
			wake();
			check("no service in halt wake", 32'(n_ack - na), 32'h0);
			wr(pmi_pkg::IDX_FLAGS, 32'h0);
		end
		// stop ignores timer3, wakes on a port1 pin then a port2 pin
		wr(pmi_pkg::IDX_POWER_OPTION, 32'h1);
		for (int j = 0; j < 2; j++) begin
			wr(j ? pmi_pkg::IDX_PORT23_WAKE : pmi_pkg::IDX_PORT1_WAKE, j ? 32'h04 : 32'h08);
			wr(pmi_pkg::IDX_POWER_CONTROL, 32'h02);
			repeat (3) @(posedge hclk);
			check("stop clocks", 32'({slow_clk_en, keep_clk_en}), 32'h0);
			fire(pmi_pkg::SLOT_RTC);
			repeat (20) @(posedge hclk);
			check("timer in stop", 32'(cpu_clk_en), 32'h0);
			port_pin[j ? 10 : 3] <= 1'b1;
			wake();
			wr(pmi_pkg::IDX_FLAGS, 32'h0);
		end
		// entry refused while enabled pin 0 is low; later a falling edge wakes
		wr(pmi_pkg::IDX_ENABLE_EXTRA, 32'h0);
		wr(pmi_pkg::IDX_PORT1_WAKE, 32'h0);
		wr(pmi_pkg::IDX_PORT23_WAKE, 32'h0);
		wr(pmi_pkg::IDX_ENABLE_MAIN, 32'h01);
		ext_pin_n[0] <= 1'b0;
		repeat (6) @(posedge hclk);
		wr(pmi_pkg::IDX_POWER_CONTROL, 32'h02);
		repeat (3) @(posedge hclk);
		check("refused entry", 32'(cpu_clk_en), 32'h1);
		rchk("refused bit", pmi_pkg::IDX_POWER_CONTROL, 32'h0);
		ext_pin_n[0] <= 1'b1;
		repeat (6) @(posedge hclk);
		wr(pmi_pkg::IDX_FLAGS, 32'h0);
		wr(pmi_pkg::IDX_POWER_CONTROL, 32'h02);
		repeat (3) @(posedge hclk);
		check("stop entered", 32'(cpu_clk_en), 32'h0);
		na = n_ack;
		ext_pin_n[0] <= 1'b0;
		wake();
		check("pin wake without global", 32'(n_ack - na), 32'h0);
		wr(pmi_pkg::IDX_ENABLE_MAIN, 32'h81);
		take(pmi_pkg::SLOT_INT0);
		rchk("pin flag after entry", pmi_pkg::IDX_FLAGS, 32'h0);
		ext_pin_n[0] <= 1'b1;
		ret();
		give_verdict();
	end
endmodule
